// ---- design/fsic_pkg.sv ----
// Constants and types of the flash security, index and configuration registers.
// Assumes an 8-bit register port at byte offsets and a nonvolatile reader elsewhere.
package fsic_pkg;
    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [4:0] OFF_LOCK_STATE = 5'h01;
    localparam logic [4:0] OFF_CMD_INDEX = 5'h02;
    localparam logic [4:0] OFF_ECC_INDEX = 5'h03;
    localparam logic [4:0] OFF_CONFIG = 5'h04;
    localparam logic [4:0] OFF_STATUS = 5'h06;
    localparam logic [4:0] OFF_CMD_DATA_HI = 5'h0A;
    localparam logic [4:0] OFF_CMD_DATA_LO = 5'h0B;
    localparam logic [4:0] OFF_ECC_DATA_HI = 5'h0E;
    localparam logic [4:0] OFF_ECC_DATA_LO = 5'h0F;
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int KEY_EN_MSB = 7;
    localparam int KEY_EN_LSB = 6;
    localparam int PROT_MSB = 1;
    localparam int PROT_LSB = 0;
    localparam int INDEX_MSB = 2;
    localparam int CFG_CC_IE = 7;
    localparam int CFG_IGN_SF = 4;
    localparam int CFG_FRC_DF = 1;
    localparam int CFG_FRC_SF = 0;
    localparam int STAT_CC_FLAG = 7;
    // ------------------------------------------------------------
    // Values
    // ------------------------------------------------------------
    localparam logic [1:0] KEY_EN_ON = 2'h2;
    localparam logic [1:0] PROT_UNSECURED = 2'h2;
    localparam logic [7:0] LOCK_RST = 8'hFF;
    localparam logic [22:0] NV_SECURITY_ADDR = 23'h7FFF0F;
    localparam int ARRAY_WORDS = 8;

    typedef enum logic [1:0] {
        ST_LOAD = 2'b01,
        ST_RUN = 2'b10
    } fsic_state_e;

    typedef struct packed {
        fsic_state_e st;
        logic [7:0] lock_state;
        logic [2:0] cmd_idx;
        logic [2:0] ecc_idx;
        logic cc_ie;
        logic ign_sf;
        logic frc_df;
        logic frc_sf;
        logic [ARRAY_WORDS-1:0][15:0] cmd_arr;
        logic [ARRAY_WORDS-1:0][15:0] ecc_arr;
        logic [7:0] rdata;
        logic sf_rep;
        logic df_rep;
        logic cc_irq;
        logic sf_irq;
        logic df_irq;
        logic launch;
    } fsic_regs_s;
endpackage

// ---- design/fsic_regs.sv ----
// Lock state, index and configuration registers of the flash controller.
// Assumes all inputs come from logic on clk; the nonvolatile reader answers the
// load request at some later edge; fault status and its enables live elsewhere.
//
// Notes on behaviour
// - Lock-state register at offset 1 is read-only; writes are dropped.
// - Lock state loads from the nonvolatile security byte during reset sequence.
// - Double fault while loading sets every lock-state bit.
// - Backdoor key access enabled only for key field pattern 10.
// - Protection field reads unsecured only for pattern 10.
// - Backdoor unlock forces protection field to 10.
// - Command index at offset 2, bits 2..0 read-write, rest zero.
// - Command index picks the command-object word accessed.
// - ECC result index at offset 3, bits 2..0 read-write, rest zero.
// - ECC result index picks the result word read.
// - Config bits 7, 4, 1, 0 read-write; others read zero.
// - Command-done interrupt when enable set and done flag set.
// - Ignore-single-fault suppresses single fault report and interrupt.
// - Force-double-fault sets double fault flag on every array read.
// - Forced double fault leaves ECC results unless a real double fault.
// - Force-single-fault sets single fault flag on every array read unless ignore-single-fault is set.
// - Forced single fault leaves ECC results unless a real single fault.
// - Fault injection bits clear only by reset or by software writing zero.
// - Double fault interrupt when its enable and flag are set.
// - Writing 1 to command-done flag launches a command.
`timescale 1ns/1ps
module fsic_regs (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Register port
    input wire logic [4:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    // Nonvolatile security byte load
    output logic nv_read_req,
    output logic [22:0] nv_read_addr,
    input wire logic nv_read_valid,
    input wire logic [7:0] nv_read_data,
    input wire logic nv_read_dbl_fault,
    // Security state
    input wire logic backdoor_unlock,
    output logic backdoor_key_enabled,
    output logic part_secured,
    output logic init_done,
    // Array read fault events
    input wire logic array_read,
    input wire logic real_single_fault,
    input wire logic real_double_fault,
    input wire logic [127:0] ecc_fault_words,
    output logic single_fault_report,
    output logic double_fault_report,
    // Interrupt requests
    input wire logic command_done_flag,
    input wire logic single_fault_flag,
    input wire logic double_fault_flag,
    input wire logic single_fault_irq_enable,
    input wire logic double_fault_irq_enable,
    output logic command_done_irq,
    output logic single_fault_irq,
    output logic double_fault_irq,
    // Command control
    output logic command_launch
);
    import fsic_pkg::*;

    fsic_regs_s r;
    fsic_regs_s next_r;

    function automatic logic [7:0] pick_byte(input logic [15:0] word, input logic hi);
        pick_byte = hi ? word[15:8] : word[7:0];
    endfunction

    function automatic logic is_pattern(input logic [1:0] field, input logic [1:0] pat);
        is_pattern = (field == pat);
    endfunction

    logic running;
    logic wr_ok;
    logic rd_ok;
    logic sf_visible;
    logic real_sf_kept;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        next_r = r;
        running = (r.st == ST_RUN);
        wr_ok = wr && running;
        rd_ok = rd && running;
        // Pulses and read data fall back to zero each cycle
        next_r.sf_rep = 1'b0;
        next_r.df_rep = 1'b0;
        next_r.launch = 1'b0;
        next_r.rdata = 8'h00;
        // Ignored single faults neither report nor capture results
        real_sf_kept = real_single_fault && !r.ign_sf;
        sf_visible = real_single_fault || r.frc_sf;

        unique case (r.st)
            ST_LOAD: begin
                // Host access stays refused until this edge
                if (nv_read_valid) begin
                    next_r.lock_state = nv_read_dbl_fault ? LOCK_RST : nv_read_data;
                    next_r.st = ST_RUN;
                end
            end
            ST_RUN: begin
                if (backdoor_unlock && is_pattern(r.lock_state[KEY_EN_MSB:KEY_EN_LSB], KEY_EN_ON)) begin
                    next_r.lock_state[PROT_MSB:PROT_LSB] = PROT_UNSECURED;
                end
            end
        endcase

        if (wr_ok) begin
            unique case (addr)
                OFF_CMD_INDEX: next_r.cmd_idx = wdata[INDEX_MSB:0];
                OFF_ECC_INDEX: next_r.ecc_idx = wdata[INDEX_MSB:0];
                OFF_CONFIG: begin
                    next_r.cc_ie = wdata[CFG_CC_IE];
                    next_r.ign_sf = wdata[CFG_IGN_SF];
                    next_r.frc_df = wdata[CFG_FRC_DF];
                    next_r.frc_sf = wdata[CFG_FRC_SF];
                end
                OFF_STATUS: next_r.launch = wdata[STAT_CC_FLAG];
                OFF_CMD_DATA_HI: next_r.cmd_arr[r.cmd_idx][15:8] = wdata;
                OFF_CMD_DATA_LO: next_r.cmd_arr[r.cmd_idx][7:0] = wdata;
                default: begin
                end
            endcase
        end

        if (rd_ok) begin
            unique case (addr)
                OFF_LOCK_STATE: next_r.rdata = r.lock_state;
                OFF_CMD_INDEX: next_r.rdata = {5'h00, r.cmd_idx};
                OFF_ECC_INDEX: next_r.rdata = {5'h00, r.ecc_idx};
                OFF_CONFIG: begin
                    next_r.rdata[CFG_CC_IE] = r.cc_ie;
                    next_r.rdata[CFG_IGN_SF] = r.ign_sf;
                    next_r.rdata[CFG_FRC_DF] = r.frc_df;
                    next_r.rdata[CFG_FRC_SF] = r.frc_sf;
                end
                OFF_CMD_DATA_HI: next_r.rdata = pick_byte(r.cmd_arr[r.cmd_idx], 1'b1);
                OFF_CMD_DATA_LO: next_r.rdata = pick_byte(r.cmd_arr[r.cmd_idx], 1'b0);
                OFF_ECC_DATA_HI: next_r.rdata = pick_byte(r.ecc_arr[r.ecc_idx], 1'b1);
                OFF_ECC_DATA_LO: next_r.rdata = pick_byte(r.ecc_arr[r.ecc_idx], 1'b0);
                default: next_r.rdata = 8'h00;
            endcase
        end

        // Forced faults only flag; results need a real fault
        if (array_read && running) begin
            next_r.df_rep = real_double_fault || r.frc_df;
            next_r.sf_rep = sf_visible && !r.ign_sf;
            if (real_double_fault || real_sf_kept) begin
                next_r.ecc_arr = ecc_fault_words;
            end
        end

        // Interrupt levels lag their inputs by one clean cycle
        // command done interrupt
        next_r.cc_irq = r.cc_ie && command_done_flag;
        // single fault interrupt gated by ignore
        next_r.sf_irq = single_fault_irq_enable && single_fault_flag && !r.ign_sf;
        next_r.df_irq = double_fault_irq_enable && double_fault_flag;
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            // Secured until the security byte arrives
            r <= '0;
            r.st <= ST_LOAD;
            r.lock_state <= LOCK_RST;
        end else begin
            r <= next_r;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Read data stands one cycle, then returns to zero
    assign rdata = r.rdata;
    assign nv_read_req = (r.st == ST_LOAD);
    assign nv_read_addr = NV_SECURITY_ADDR;
    assign init_done = (r.st == ST_RUN);
    assign backdoor_key_enabled = is_pattern(r.lock_state[KEY_EN_MSB:KEY_EN_LSB], KEY_EN_ON);
    assign part_secured = !is_pattern(r.lock_state[PROT_MSB:PROT_LSB], PROT_UNSECURED);
    assign single_fault_report = r.sf_rep;
    assign double_fault_report = r.df_rep;
    assign command_done_irq = r.cc_irq;
    assign single_fault_irq = r.sf_irq;
    assign double_fault_irq = r.df_irq;
    assign command_launch = r.launch;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    a_lock_write_ignored: assert property (
        (wr && addr == OFF_LOCK_STATE && r.st == ST_RUN && !backdoor_unlock) |=> $stable(r.lock_state))
        else $error("lock state changed by a write");

    a_load_copy_byte: assert property (
        (r.st == ST_LOAD && nv_read_valid && !nv_read_dbl_fault) |=> (r.lock_state == $past(nv_read_data) && init_done))
        else $error("security byte not loaded");

    a_load_fault_secure: assert property (
        (r.st == ST_LOAD && nv_read_valid && nv_read_dbl_fault) |=> (r.lock_state == LOCK_RST && part_secured))
        else $error("double fault at load did not secure");

    a_unlock_forces_open: assert property (
        (r.st == ST_RUN && backdoor_unlock && backdoor_key_enabled) |=> !part_secured)
        else $error("backdoor unlock left part secured");

    a_index_read_back: assert property (
        (wr && addr == OFF_CMD_INDEX && init_done) ##1 !wr ##1 (rd && addr == OFF_CMD_INDEX)
        |=> rdata == ($past(wdata, 3) & 8'h07))
        else $error("command index read back wrong");

    a_ecc_index_clear: assert property (
        (rd && addr == OFF_ECC_INDEX && init_done) |=> rdata[7:3] == 5'h00)
        else $error("ecc index upper bits not zero");

    a_force_double_flag: assert property (
        (init_done && array_read && r.frc_df) |=> double_fault_report)
        else $error("forced double fault not reported");

    a_ignore_single: assert property (
        (init_done && array_read && r.ign_sf) |=> !single_fault_report)
        else $error("single fault reported while ignored");

    a_ecc_results_hold: assert property (
        (array_read && !real_double_fault && !(real_single_fault && !r.ign_sf)) |=> $stable(r.ecc_arr))
        else $error("ecc results changed without a real fault");

    a_cc_irq_gate: assert property (
        (!r.cc_ie && !$past(r.cc_ie)) |=> !command_done_irq)
        else $error("command done interrupt while disabled");

    a_early_access_refused: assert property (
        (r.st == ST_LOAD && rd) |=> rdata == 8'h00)
        else $error("read answered before lock state loaded");

    // ------------------------------------------------------------
    // Load and lock state
    // ------------------------------------------------------------
    a_load_waits_byte: assert property (
        (r.st == ST_LOAD && !nv_read_valid) |=> !init_done)
        else $error("load ended without the security byte");

    a_init_sticky: assert property (
        init_done |=> init_done)
        else $error("load state entered again without reset");

    a_early_write_dropped: assert property (
        (r.st == ST_LOAD && wr) |=> ($stable(r.cmd_idx) && $stable(r.ecc_idx)))
        else $error("index written before load");

    a_lock_run_stable: assert property (
        (init_done && !backdoor_unlock) |=> $stable(r.lock_state))
        else $error("lock state changed while running");

    a_unlock_needs_key: assert property (
        (init_done && backdoor_unlock && !backdoor_key_enabled) |=> $stable(r.lock_state))
        else $error("unlock taken with key disabled");

    // ------------------------------------------------------------
    // Register port
    // ------------------------------------------------------------
    a_cmd_index_clear: assert property (
        (init_done && rd && addr == OFF_CMD_INDEX) |=> rdata[7:3] == 5'h00)
        else $error("command index upper bits not zero");

    a_ecc_index_write: assert property (
        (init_done && wr && addr == OFF_ECC_INDEX) |=> ({5'h00, r.ecc_idx} == ($past(wdata) & 8'h07)))
        else $error("ecc index not written");

    a_config_write_back: assert property (
        (init_done && wr && addr == OFF_CONFIG)
        |=> ({r.cc_ie, 2'b00, r.ign_sf, 2'b00, r.frc_df, r.frc_sf} == ($past(wdata) & 8'h93)))
        else $error("config bits not written");

    a_config_zero_bits: assert property (
        (init_done && rd && addr == OFF_CONFIG) |=> ((rdata & 8'h6C) == 8'h00))
        else $error("unused config bits not zero");

    a_inject_bits_sticky: assert property (
        (!(wr && addr == OFF_CONFIG)) |=> ($stable(r.frc_df) && $stable(r.frc_sf)))
        else $error("fault injection bit changed without a write");

    a_launch_pulse: assert property (
        (init_done && wr && addr == OFF_STATUS && wdata[STAT_CC_FLAG]) |=> command_launch)
        else $error("launch write gave no pulse");

    a_launch_quiet: assert property (
        (!(wr && addr == OFF_STATUS)) |=> !command_launch)
        else $error("launch pulse without a write");

    // ------------------------------------------------------------
    // Fault reports and interrupts
    // ------------------------------------------------------------
    a_report_idle: assert property (
        (!array_read) |=> (!double_fault_report && !single_fault_report))
        else $error("fault report without an array read");

    a_double_quiet: assert property (
        (init_done && array_read && !r.frc_df && !real_double_fault) |=> !double_fault_report)
        else $error("double fault reported without cause");

    a_force_single_flag: assert property (
        (init_done && array_read && r.frc_sf && !r.ign_sf) |=> single_fault_report)
        else $error("forced single fault not reported");

    a_single_quiet: assert property (
        (init_done && array_read && !r.frc_sf && !real_single_fault) |=> !single_fault_report)
        else $error("single fault reported without cause");

    a_results_real_double: assert property (
        (init_done && array_read && real_double_fault) |=> (r.ecc_arr == $past(ecc_fault_words)))
        else $error("real double fault not captured");

    a_results_real_single: assert property (
        (init_done && array_read && real_single_fault && !r.ign_sf) |=> (r.ecc_arr == $past(ecc_fault_words)))
        else $error("real single fault not captured");

    a_cc_irq_follow: assert property (
        (r.cc_ie && command_done_flag) |=> command_done_irq)
        else $error("command done interrupt missing");

    a_sf_irq_ignored: assert property (
        r.ign_sf |=> !single_fault_irq)
        else $error("single fault interrupt while ignored");

    a_df_irq_follow: assert property (
        (double_fault_irq_enable && double_fault_flag) |=> double_fault_irq)
        else $error("double fault interrupt missing");

    c_load_done: cover property (r.st == ST_LOAD ##1 r.st == ST_RUN);
    c_backdoor_open: cover property (backdoor_unlock && backdoor_key_enabled ##1 !part_secured);
    c_forced_double: cover property (array_read && r.frc_df && !real_double_fault ##1 double_fault_report);
    c_launch: cover property (command_launch);
    c_ignored_single: cover property (array_read && r.ign_sf && real_single_fault);
endmodule

// ---- testbench/test_fsic_regs.sv ----
// Self-checking bench for the lock state, index and configuration registers.
// Assumes the bench alone drives every port; reads and events are noted in queues.
`timescale 1ns/1ps
module test_fsic_regs;
    import fsic_pkg::*;
    logic clk, resetn, wr, rd, nv_read_valid, nv_read_dbl_fault, backdoor_unlock;
    logic array_read, real_single_fault, real_double_fault, command_done_flag;
    logic single_fault_flag, double_fault_flag, single_fault_irq_enable, double_fault_irq_enable;
    logic nv_read_req, backdoor_key_enabled, part_secured, init_done, single_fault_report;
    logic double_fault_report, command_done_irq, single_fault_irq, double_fault_irq, command_launch;
    logic [4:0] addr;
    logic [7:0] wdata, rdata, nv_read_data, cfg, v;
    logic [22:0] nv_read_addr;
    logic [127:0] ecc_fault_words, ecc_now;
    logic [15:0] cmd_exp [8];
    logic [4:0] irq_in;
    logic [1:0] k;
    logic rd_seen;
    logic [7:0] rd_notes [$];
    logic [2:0] ev_notes [$];
    int seed = 32'h63CEAC4B;
    int fail_count = 0;
    int checks_done = 0;

    fsic_regs DUT (.clk, .resetn, .addr, .wdata, .wr, .rd, .rdata, .nv_read_req, .nv_read_addr,
        .nv_read_valid, .nv_read_data, .nv_read_dbl_fault, .backdoor_unlock, .backdoor_key_enabled,
        .part_secured, .init_done, .array_read, .real_single_fault, .real_double_fault,
        .ecc_fault_words, .single_fault_report, .double_fault_report, .command_done_flag,
        .single_fault_flag, .double_fault_flag, .single_fault_irq_enable, .double_fault_irq_enable,
        .command_done_irq, .single_fault_irq, .double_fault_irq, .command_launch);

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // ------------------------------------------------------------
    // Compare and report
    // ------------------------------------------------------------
    task note(input logic ok, input string n, input logic [7:0] e, input logic [7:0] g);
        checks_done++;
        if (!ok) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    task cmp_read(input logic [7:0] e, input logic [7:0] g);
        note(g === e, "read data", e, g);
    endtask
    task cmp_event(input logic [2:0] e, input logic [2:0] g);
        note(g === e, "event pulses", {5'h00, e}, {5'h00, g});
    endtask
    task cmp_level(input string n, input logic e, input logic g);
        note(g === e, n, {7'h00, e}, {7'h00, g});
    endtask
    task conclude;
        // Notes never answered mean a result that did not appear
        note(rd_notes.size() + ev_notes.size() == 0, "pending notes", 8'h00, 8'(rd_notes.size()));
        $display("checks_done=%0d fail_count=%0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Watcher: read data one cycle after rd, pulses whenever they appear
    // ------------------------------------------------------------
    always @(posedge clk) rd_seen <= rd;
    always @(negedge clk) begin
        if (rd_seen) begin
            if (rd_notes.size() > 0) cmp_read(rd_notes.pop_front(), rdata);
            else note(1'b0, "unnoted read", 8'h00, rdata);
        end
        if ({command_launch, double_fault_report, single_fault_report} !== 3'b000) begin
            if (ev_notes.size() > 0) cmp_event(ev_notes.pop_front(), {command_launch, double_fault_report,
                single_fault_report});
            else note(1'b0, "unnoted pulse", 8'h00, {5'h00, command_launch, double_fault_report,
                single_fault_report});
        end
    end

    // ------------------------------------------------------------
    // Drivers
    // ------------------------------------------------------------
    task wr_reg(input logic [4:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task rd_reg(input logic [4:0] a, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        rd_notes.push_back(e);
        @(posedge clk);
        rd <= 1'b0;
    endtask
    task set_cfg(input logic [7:0] d);
        cfg = d & 8'h93;
        wr_reg(OFF_CONFIG, d);
    endtask
    task do_reset(input logic [7:0] d, input logic dbl);
        int n;
        @(posedge clk);
        resetn <= 1'b0;
        repeat (5) @(posedge clk);
        resetn <= 1'b1;
        cfg = 8'h00;
        ecc_now = '0;
        wr_reg(OFF_CMD_INDEX, 8'h05);
        rd_reg(OFF_LOCK_STATE, 8'h00);
        cmp_level("nv request", 1'b1, nv_read_req);
        @(posedge clk);
        nv_read_valid <= 1'b1;
        nv_read_data <= d;
        nv_read_dbl_fault <= dbl;
        @(posedge clk);
        nv_read_valid <= 1'b0;
        n = 0;
        while (init_done !== 1'b1 && n < 20) begin
            @(negedge clk);
            n++;
        end
        cmp_level("nv request", 1'b0, nv_read_req);
        if (n == 20) begin
            note(1'b0, "load wait", 8'h01, 8'h00);
            conclude();
        end
        rd_reg(OFF_CMD_INDEX, 8'h00);
    endtask
    task arr(input logic sf, input logic df);
        logic [127:0] w;
        w = {$random(seed), $random(seed), $random(seed), $random(seed)};
        @(posedge clk);
        array_read <= 1'b1;
        real_single_fault <= sf;
        real_double_fault <= df;
        ecc_fault_words <= w;
        // Forced faults alone must not disturb the captured results
        if (df || (sf && !cfg[4])) ecc_now = w;
        if ((df | cfg[1]) || ((sf | cfg[0]) && !cfg[4]))
            ev_notes.push_back({1'b0, df | cfg[1], (sf | cfg[0]) & ~cfg[4]});
        @(posedge clk);
        array_read <= 1'b0;
    endtask
    task chk_ecc;
        for (int j = 0; j < 8; j++) begin
            wr_reg(OFF_ECC_INDEX, 8'(j));
            rd_reg(OFF_ECC_DATA_HI, ecc_now[16*j+8 +: 8]);
            rd_reg(OFF_ECC_DATA_LO, ecc_now[16*j +: 8]);
        end
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        {resetn, wr, rd, nv_read_valid, nv_read_dbl_fault, backdoor_unlock, array_read} = '0;
        {real_single_fault, real_double_fault, irq_in} = '0;
        {command_done_flag, single_fault_flag, double_fault_flag} = '0;
        {single_fault_irq_enable, double_fault_irq_enable} = '0;
        {addr, wdata, nv_read_data, ecc_fault_words, cfg} = '0;
        for (int i = 0; i < 4; i++) begin
            k = i[1:0];
            v = {k, 4'hF, ~k}; // spare bits kept erased
            do_reset(v, 1'b0);
            @(negedge clk);
            cmp_level("key enabled", k == 2'b10, backdoor_key_enabled);
            cmp_level("secured", k != 2'b01, part_secured);
            cmp_level("nv address", 1'b1, nv_read_addr === NV_SECURITY_ADDR);
            wr_reg(OFF_LOCK_STATE, ~v);
            rd_reg(OFF_LOCK_STATE, v);
            @(posedge clk);
            backdoor_unlock <= 1'b1;
            @(posedge clk);
            backdoor_unlock <= 1'b0;
            rd_reg(OFF_LOCK_STATE, (k == 2'b10) ? 8'hBE : v);
        end
        do_reset(8'hBE, 1'b1);
        rd_reg(OFF_LOCK_STATE, 8'hFF);
        @(negedge clk);
        cmp_level("key after fault", 1'b0, backdoor_key_enabled);
        cmp_level("secured after fault", 1'b1, part_secured);
        repeat (4) begin
            v = 8'($random(seed));
            wr_reg(OFF_CMD_INDEX, v);
            rd_reg(OFF_CMD_INDEX, v & 8'h07);
            wr_reg(OFF_ECC_INDEX, ~v);
            rd_reg(OFF_ECC_INDEX, ~v & 8'h07);
            set_cfg(8'($random(seed)));
            rd_reg(OFF_CONFIG, cfg);
        end
        for (int j = 0; j < 8; j++) begin
            cmd_exp[j] = 16'($random(seed));
            wr_reg(OFF_CMD_INDEX, 8'(j));
            wr_reg(OFF_CMD_DATA_HI, cmd_exp[j][15:8]);
            wr_reg(OFF_CMD_DATA_LO, cmd_exp[j][7:0]);
        end
        for (int j = 7; j >= 0; j--) begin
            wr_reg(OFF_CMD_INDEX, 8'(j));
            rd_reg(OFF_CMD_DATA_HI, cmd_exp[j][15:8]);
            rd_reg(OFF_CMD_DATA_LO, cmd_exp[j][7:0]);
        end
        wr_reg(5'h1F, 8'hFF);
        rd_reg(5'h1F, 8'h00);
        set_cfg(8'h00);
        arr(1'b1, 1'b0);
        set_cfg(8'h02);
        arr(1'b0, 1'b0);
        arr(1'b0, 1'b0);
        chk_ecc();
        arr(1'b0, 1'b1);
        set_cfg(8'h01);
        arr(1'b0, 1'b0);
        chk_ecc();
        arr(1'b1, 1'b0);
        set_cfg(8'h11);
        arr(1'b1, 1'b0);
        chk_ecc();
        set_cfg(8'h00);
        arr(1'b0, 1'b0);
        rd_reg(OFF_CONFIG, 8'h00);
        repeat (8) begin
            irq_in = 5'($random(seed));
            @(posedge clk);
            {command_done_flag, single_fault_flag, double_fault_flag} <= irq_in[4:2];
            {single_fault_irq_enable, double_fault_irq_enable} <= irq_in[1:0];
            set_cfg(8'($random(seed)));
            repeat (2) @(posedge clk);
            @(negedge clk);
            cmp_level("done irq", cfg[7] & irq_in[4], command_done_irq);
            cmp_level("single irq", irq_in[1] & irq_in[3] & ~cfg[4], single_fault_irq);
            cmp_level("double irq", irq_in[0] & irq_in[2], double_fault_irq);
        end
        ev_notes.push_back(3'b100);
        wr_reg(OFF_STATUS, 8'h80);
        wr_reg(OFF_STATUS, 8'h7F);
        repeat (4) @(posedge clk);
        conclude();
    end
endmodule
